/* File: tb/sensor_monitor_drp_readout_bench.sv */
// Self-checking bench for the sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch %0t value differs", $time); end end
module sensor_monitor_drp_readout_bench;
  logic core_clk = 1'b0, sys_rst = 1'b1, port_enable, port_write, port_done;
  logic busy, end_of_conversion, end_of_sequence, aux_supply_alarm;
  logic rd_stb, hung;
  logic [6:0] port_addr;
  logic [15:0] port_wdata, port_rdata, rd_data, sample_code = 16'h0000;
  logic [4:0] channel;
  logic [3:0] alarm_outputs, exp_alarm;
  logic [15:0] exp_rd;
  logic [15:0] code [9], ex [9];
  logic [31:0] rs = 32'h848e;
  int bad_count, check_count, cfg_n, p, n;
  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // Code slot of a channel or address
  function automatic int ix(input logic [6:0] v, input int off);
    return v < 3 ? v : v == 6 ? 3 : v >= off && v < off + 4 ? v - off + 4 : 8;
  endfunction
  // New codes, alarm limit corners on early passes
  task automatic rnd;
    for (int i = 0; i < 9; i++) begin
      rs = xs(rs);
      code[i] = rs[15:0];
    end
    code[2] = p == 1 ? 16'ha147 : p == 2 ? 16'ha148 : code[2];
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always #12.5 core_clk = ~core_clk;
  smdr_core #(.CONV_CYCLES(4)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .port_enable(port_enable), .port_write(port_write), .busy(busy),
    .port_addr(port_addr), .port_wdata(port_wdata), .port_done(port_done),
    .port_rdata(port_rdata), .sample_code(sample_code), .channel(channel),
    .end_of_conversion(end_of_conversion), .end_of_sequence(end_of_sequence),
    .alarm_outputs(alarm_outputs), .aux_supply_alarm(aux_supply_alarm));
  smdr_host host (.core_clk(core_clk), .sys_rst(sys_rst), .busy(busy),
    .end_of_sequence(end_of_sequence), .port_done(port_done),
    .port_rdata(port_rdata), .port_enable(port_enable), .rd_data(rd_data),
    .port_write(port_write), .port_addr(port_addr), .port_wdata(port_wdata),
    .rd_stb(rd_stb), .hung(hung));
  // Codes per slot, alarm and read checks
  always @(posedge core_clk) begin
    sample_code <= code[ix(channel, 10)];
    if (end_of_sequence) begin
      exp_alarm = {code[3] > smdr_pkg::LIMIT_BRAM_RST,
                   code[2] > smdr_pkg::LIMIT_VCCAUX_RST,
                   code[1] > smdr_pkg::LIMIT_VCCINT_RST,
                   code[0] > smdr_pkg::LIMIT_TEMP_RST};
      `CHK(alarm_outputs, exp_alarm)
      `CHK(aux_supply_alarm, exp_alarm[2])
      ex <= code;
      p++;
      $display("pass %0d done", p);
      rnd();
    end
    if (rd_stb) begin
      exp_rd = cfg_n == 0 ? smdr_pkg::CONFIG_ZERO_RST :
               cfg_n < 3 ? 16'h0000 : ex[(cfg_n - 3) % 8];
      `CHK(rd_data, exp_rd)
      cfg_n++;
    end
  end
  // Reset, run six passes
  initial begin
    rnd();
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (n = 0; n < 500 && p < 6; n++) @(posedge core_clk);
    `CHK(hung, 1'b0)
    `CHK(n < 500, 1'b1)
    give_verdict();
  end
endmodule
bind smdr_core smdr_core_properties #(.CONV_CYCLES(CONV_CYCLES)) chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .port_enable(port_enable),
  .port_done(port_done), .busy(busy), .end_of_conversion(end_of_conversion),
  .end_of_sequence(end_of_sequence), .aux_supply_alarm(aux_supply_alarm),
  .channel(channel), .alarm_outputs(alarm_outputs));

/* File: tb/smdr_core_properties.sv */
// Port timing, channel order, slot length and alarm checks for the sequencer
`timescale 1ns/1ps
module smdr_core_properties #(parameter int CONV_CYCLES = 4) (
  // Clock, reset and port
  input wire logic       core_clk, sys_rst, port_enable, port_done,
  // Sequencer status
  input wire logic       busy, end_of_conversion, end_of_sequence,
  input wire logic       aux_supply_alarm,
  input wire logic [4:0] channel,
  input wire logic [3:0] alarm_outputs
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] run;
  logic       seen;
  // Successor in the channel list
  function automatic logic [4:0] nxt(input logic [4:0] c);
    return c == 5'h08 ? 5'h00 : c == 5'h03 ? 5'h06 : c == 5'h06 ? 5'h0a :
           c == 5'h0d ? 5'h08 : c + 5'h01;
  endfunction
  // Slot length and first full pass
  always_ff @(posedge core_clk) begin
    run <= $changed(channel) ? 8'h01 : run + 8'h01;
    seen <= !sys_rst && (seen || end_of_sequence);
  end
  chk_done_two: assert property (port_enable |-> ##2 port_done)
    else $error("done late");
  chk_done_once: assert property (port_done |=> !port_done)
    else $error("done too long");
  chk_eos_pulse: assert property (end_of_sequence |=> !end_of_sequence)
    else $error("sequence end too long");
  chk_eos_eoc: assert property (end_of_sequence |-> end_of_conversion)
    else $error("sequence end off slot");
  chk_chan_order: assert property (!$past(busy) && $changed(channel)
    |-> channel == nxt($past(channel))) else $error("bad channel order");
  chk_cal_slot: assert property (seen && $changed(channel) &&
    $past(channel) == 5'h08 |-> run == 3 * CONV_CYCLES) else $error("cal");
  chk_slot_len: assert property (seen && $changed(channel) &&
    $past(channel) != 5'h08 |-> run == CONV_CYCLES) else $error("slot");
  chk_alarm_load: assert property ($changed(aux_supply_alarm)
    |-> end_of_conversion && channel == 5'h02)
    else $error("alarm off slot end");
  chk_aux_mirror: assert property (aux_supply_alarm == alarm_outputs[2])
    else $error("aux alarm differs");
  chk_busy_cal: assert property (seen && busy |-> channel == 5'h08)
    else $error("busy outside calibration");
  cover property (end_of_sequence);
  cover property ($rose(aux_supply_alarm));
  cover property (port_done);
endmodule

/* File: tb/smdr_host.sv */
// Host model on the reconfiguration port
`timescale 1ns/1ps
module smdr_host (
  // Clock, reset and status
  input wire logic        core_clk, sys_rst, busy, end_of_sequence,
  input wire logic        port_done,
  input wire logic [15:0] port_rdata,
  // Port requests
  output logic            port_enable, port_write,
  output logic [6:0]      port_addr,
  output logic [15:0]     port_wdata,
  // Captured reads
  output logic            rd_stb, hung,
  output logic [15:0]     rd_data
);
  int n;
  // One access, strobe for one cycle
  task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d);
    int k;
    @(posedge core_clk);
    port_enable <= 1'b1;
    port_write <= w;
    port_addr <= a;
    port_wdata <= d;
    @(posedge core_clk);
    port_enable <= 1'b0;
    for (k = 0; k < 8 && !port_done; k++) @(posedge core_clk);
    hung <= hung || k == 8;
    rd_data <= port_rdata;
    rd_stb <= !w;
    port_addr <= ~a;
    port_wdata <= ~d;
    @(posedge core_clk);
    rd_stb <= 1'b0;
  endtask
  // Startup then reads after each pass
  initial begin
    {port_enable, port_write, rd_stb, hung} = 4'h0;
    port_addr = 7'h00;
    port_wdata = 16'h0000;
    rd_data = 16'h0000;
    @(posedge core_clk);
    for (n = 0; n < 300 && (sys_rst || busy); n++)
      @(posedge core_clk);
    hung <= n == 300;
    acc(1'b0, 7'h40, 16'h0000);
    acc(1'b1, 7'h40, rd_data & 16'h03ff);
    acc(1'b0, 7'h40, 16'h0000);
    acc(1'b0, 7'h7f, 16'h0000);
    forever begin
      for (n = 0; n < 300 && !end_of_sequence; n++) @(posedge core_clk);
      hung <= hung || n == 300;
      for (int i = 0; i < 8; i++)
        acc(1'b0, 7'(i < 3 ? i : i == 3 ? 6 : i + 12), 16'h0000);
    end
  end
endmodule

/* File: verilog/smdr_core.sv */
// Monitor converter sequencer with reconfiguration port
// Operation
// - End-of-sequence pulses one clock per pass
// - Current channel shown on five-bit bus
// - Order 8,0,1,2,3,6,10,11,12,13 repeating
// - Calibration slot spans three conversions
// - Results 16 bit, 12-bit MSB justified
// - Supply alarm updates when result loaded
// - Alarm high when result exceeds limit
`timescale 1ns/1ps
module smdr_core #(
  parameter int CONV_CYCLES = smdr_pkg::CONV_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Reconfiguration port
  input  wire logic        port_enable,
  input  wire logic        port_write,
  input  wire logic [6:0]  port_addr,
  input  wire logic [15:0] port_wdata,
  output logic [15:0]      port_rdata,
  output logic             port_done,
  // Conversion sample input, 16-bit code per channel slot
  input  wire logic [15:0] sample_code,
  // Status
  output logic             busy,
  output logic [4:0]       channel,
  output logic             end_of_conversion,
  output logic             end_of_sequence,
  output logic [3:0]       alarm_outputs,
  output logic             aux_supply_alarm
);
  // Slot counter is eight bits wide, so slots span 2 to 256 cycles
  if (CONV_CYCLES < 2 || CONV_CYCLES > 256) begin : g_bad_conv
    $error("CONV_CYCLES must lie between 2 and 256");
  end

  // Fixed channel order
  // Wraps back to calibration after the last aux channel
  function automatic logic [4:0] seq_ch(input logic [3:0] idx);
    case (idx)
      4'h0:    seq_ch = 5'h08;
      4'h1:    seq_ch = 5'h00;
      4'h2:    seq_ch = 5'h01;
      4'h3:    seq_ch = 5'h02;
      4'h4:    seq_ch = 5'h03;
      4'h5:    seq_ch = 5'h06;
      4'h6:    seq_ch = 5'h0a;
      4'h7:    seq_ch = 5'h0b;
      4'h8:    seq_ch = 5'h0c;
      default: seq_ch = 5'h0d;
    endcase
  endfunction

  // Status slot of a channel: 0..3 supplies, 4..7 aux, 8 none
  // Registers with no result slot, other than config zero and the limits, read back as zero
  function automatic logic [3:0] slot_of(input logic [4:0] ch);
    case (ch)
      5'h00:   slot_of = 4'h0;
      5'h01:   slot_of = 4'h1;
      5'h02:   slot_of = 4'h2;
      5'h06:   slot_of = 4'h3;
      5'h10:   slot_of = 4'h4;
      5'h11:   slot_of = 4'h5;
      5'h12:   slot_of = 4'h6;
      5'h13:   slot_of = 4'h7;
      default: slot_of = 4'h8;
    endcase
  endfunction

  // Startup wait, then free-running conversion slots
  typedef enum logic [1:0] {
    SMDR_INIT = 2'b00,
    SMDR_CONV = 2'b01
  } smdr_state_e;

  // Sequencer state and counters
  smdr_state_e state;
  logic [4:0]  busy_cnt;
  logic [7:0]  conv_cnt;
  logic [1:0]  cal_cnt;
  logic [3:0]  seq_idx;
  logic [15:0] config_zero;
  logic [15:0] limit_mem [0:3];
  // Result slots 0..3 hold supplies, 4..7 the aux channels
  logic [15:0] result_mem [0:7];
  logic        port_pipe;
  logic [6:0]  addr_hold;

  // Slot decode and conversion end
  wire logic [4:0] cur_ch    = seq_ch(seq_idx);
  // Aux channels 10..13 keep their results at registers 10h..13h,
  // so their number moves up by six before the slot lookup
  wire logic [4:0] cur_reg   = (cur_ch >= 5'h0a) ? cur_ch + 5'h06 : cur_ch;
  wire logic [3:0] cur_slot  = slot_of(cur_reg);
  wire logic       conv_last = (conv_cnt == 8'(CONV_CYCLES - 1));
  wire logic       is_cal    = (cur_ch == smdr_pkg::CH_CAL);
  wire logic       slot_done = conv_last &&
    (!is_cal || cal_cnt == 2'(smdr_pkg::CAL_CONVERSIONS - 1));
  wire logic       seq_wrap  = (seq_idx == 4'(smdr_pkg::SEQ_LEN - 1));
  wire logic [3:0] addr_slot = slot_of(addr_hold[4:0]);
  wire logic       addr_lim  = (addr_hold[6:2] ==
                                smdr_pkg::ADDR_LIMIT_BASE[6:2]);
  // Writes take effect on the taking edge
  wire logic       wr_cfg    = port_enable && port_write &&
                               port_addr == smdr_pkg::ADDR_CONFIG_ZERO;
  wire logic       wr_lim    = port_enable && port_write &&
                               port_addr[6:2] ==
                               smdr_pkg::ADDR_LIMIT_BASE[6:2];

  // Sequencer
  // Slot counter restarts each conversion; index steps per slot
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state    <= SMDR_INIT;
      busy_cnt <= 5'h00;
      conv_cnt <= 8'h00;
      cal_cnt  <= 2'h0;
      seq_idx  <= 4'h0;
    end else begin
      case (state)
        SMDR_INIT: begin
          // Startup wait matches the busy period
          busy_cnt <= busy_cnt + 5'h01;
          if (busy_cnt == 5'(smdr_pkg::BUSY_RST_CYCLES - 1))
            state <= SMDR_CONV;
        end
        SMDR_CONV: begin
          conv_cnt <= conv_last ? 8'h00 : conv_cnt + 8'h01;
          // Calibration repeats the conversion three times
          if (conv_last) begin
            cal_cnt <= slot_done ? 2'h0 : cal_cnt + 2'h1;
          end
          if (slot_done) begin
            seq_idx <= seq_wrap ? 4'h0 : seq_idx + 4'h1;
          end
        end
        default: state <= SMDR_INIT;
      endcase
    end
  end

  // Status outputs, results and alarms
  // All status outputs are registered, one cycle behind the slot
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy              <= 1'b1;
      channel           <= 5'h00;
      end_of_conversion <= 1'b0;
      end_of_sequence   <= 1'b0;
      alarm_outputs     <= 4'h0;
      for (int i = 0; i < 8; i++) result_mem[i] <= 16'h0000;
    end else begin
      // Busy over startup and at each calibration step start
      busy              <= (state == SMDR_INIT) ||
                           (is_cal && conv_cnt == 8'h00);
      channel           <= cur_ch;
      end_of_conversion <= (state == SMDR_CONV) && slot_done;
      end_of_sequence   <= (state == SMDR_CONV) && slot_done
                           && seq_wrap;
      // Result and alarm load on one edge, never apart
      if (state == SMDR_CONV && slot_done && cur_slot != 4'h8) begin
        result_mem[cur_slot[2:0]] <= sample_code;
        if (cur_slot < 4'h4)
          alarm_outputs[cur_slot[1:0]] <=
            (sample_code > limit_mem[cur_slot[1:0]]);
      end
    end
  end

  // Aux supply alarm is the vccaux bit
  assign aux_supply_alarm = alarm_outputs[2];

  // Configuration register zero and upper limits
  // Only config zero and the four upper limits are writable
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      config_zero  <= smdr_pkg::CONFIG_ZERO_RST;
      limit_mem[0] <= smdr_pkg::LIMIT_TEMP_RST;
      limit_mem[1] <= smdr_pkg::LIMIT_VCCINT_RST;
      limit_mem[2] <= smdr_pkg::LIMIT_VCCAUX_RST;
      limit_mem[3] <= smdr_pkg::LIMIT_BRAM_RST;
    end else begin
      // Averaging bits are held only; slot timing ignores them
      if (wr_cfg) config_zero <= port_wdata;
      // New limits apply from the next loaded result
      if (wr_lim) limit_mem[port_addr[1:0]] <= port_wdata;
    end
  end

  // Port access: enable is registered into port_pipe first, so read data and done
  // both appear on the second edge after the taking edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_pipe  <= 1'b0;
      addr_hold  <= 7'h00;
      port_rdata <= 16'h0000;
      port_done  <= 1'b0;
    end else begin
      port_pipe <= port_enable;
      // Address held for the answer cycle
      if (port_enable) addr_hold <= port_addr;
      port_done <= port_pipe;
      if (port_pipe) begin
        if (addr_hold == smdr_pkg::ADDR_CONFIG_ZERO)
          port_rdata <= config_zero;
        else if (addr_lim)
          port_rdata <= limit_mem[addr_hold[1:0]];
        else if (addr_hold[6:5] == 2'b00 && addr_slot != 4'h8)
          port_rdata <= result_mem[addr_slot[2:0]];
        else
          port_rdata <= 16'h0000;
      end
    end
  end
endmodule

/* File: verilog/smdr_pkg.sv */
// Package of constants for the monitor converter sequencer
package smdr_pkg;
  // Register addresses on the reconfiguration port
  localparam logic [6:0]  ADDR_TEMP        = 7'h00;
  localparam logic [6:0]  ADDR_VCCINT      = 7'h01;
  localparam logic [6:0]  ADDR_VCCAUX      = 7'h02;
  localparam logic [6:0]  ADDR_VCCBRAM     = 7'h06;
  localparam logic [6:0]  ADDR_AUX0        = 7'h10;
  localparam logic [6:0]  ADDR_CONFIG_ZERO = 7'h40;
  localparam logic [6:0]  ADDR_LIMIT_BASE  = 7'h50;
  // Averaging selection field in config register zero
  localparam int          AVG_LOW_POS      = 12;
  localparam int          AVG_HIGH_POS     = 13;
  // Reset values
  localparam logic [15:0] CONFIG_ZERO_RST  = 16'h9000;
  localparam logic [15:0] LIMIT_TEMP_RST   = 16'hb5ed;
  localparam logic [15:0] LIMIT_VCCINT_RST = 16'h5999;
  localparam logic [15:0] LIMIT_VCCAUX_RST = 16'ha147;
  localparam logic [15:0] LIMIT_BRAM_RST   = 16'h5999;
  // Sequence
  localparam int          SEQ_LEN          = 10;
  localparam logic [4:0]  CH_CAL           = 5'h08;
  // Timing in cycles
  localparam int          CONV_CYCLES      = 26;
  localparam int          CAL_CONVERSIONS  = 3;
  localparam int          BUSY_RST_CYCLES  = 16;
  localparam int          PORT_LATENCY     = 2;
endpackage
